// ==== verilog/redriver_config_registers.sv ====
// Configuration register bank of the redriver mux, offset/data strobes
//
// Contract
// - General bit 7: linear or limited mode
// - General bit 4: equalizer from straps or registers
// - General bit 2: normal or flipped orientation
// - USB enable codes 1 and 3 enable
// - Shaping bits 7-6 pick pre-shoot level
// - Pre-shoot enable, only honoured in limited mode
// - Shaping bits 4-3 pick de-emphasis level
// - De-emphasis enable, only honoured in limited mode
// - Adaptive bits 7-4: full search upper limit
// - Adaptive bit 3: idle enters U1 or U3
// - Adaptive bits 2-1 pick adaptation algorithm
// - Adaptive bit 0 enables adaptive equalization
// - Offset 1Dh: limits and signed final adjustment
// - Reads auto-increment; after NACK, hold until stop
`timescale 1ns/10ps
module redriver_config_registers (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ofs_load,
  input wire logic [7:0] i_ofs,
  input wire logic i_wr_stb,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_stb,
  input wire logic i_rd_nack,
  input wire logic i_stop,
  output logic [7:0] o_rd_data,
  output logic o_tx_enable,
  output logic [7:0] o_pointer,
  output redriver_cfg_pkg::cfg_s o_cfg
);
  import redriver_cfg_pkg::*;

  // ****************************************************************
  // Offset pointer and read hold-off
  // ****************************************************************
  logic [7:0] ptr_r;
  logic hold_r;
  logic rd_take;
  logic [7:0] gen_q, txs_q, apr_q, asc_q;
  logic [7:0] rd_mux;
  logic [7:0] rd_data_r;

  // A read after NACK is ignored so the pointer does not run on
  assign rd_take = i_rd_stb & ~hold_r;

  // Offset byte of a write sets the pointer; data bytes follow it
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_r <= BYTE_ZERO;
    end else if (i_ofs_load) begin
      ptr_r <= i_ofs;
    end else if (i_wr_stb || rd_take) begin
      ptr_r <= ptr_r + OFS_STEP;
    end
  end

  // NACK sets, stop clears; a NACK in the stop cycle still holds
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_r <= 1'b0;
    end else if (i_rd_nack) begin
      hold_r <= 1'b1;
    end else if (i_stop) begin
      hold_r <= 1'b0;
    end
  end

  assign o_tx_enable = ~hold_r;
  assign o_pointer = ptr_r;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic we_gen, we_txs, we_apr, we_asc;

  // Revision has no write path at all
  assign we_gen = i_wr_stb && (ptr_r == OFS_GENERAL);
  assign we_txs = i_wr_stb && (ptr_r == OFS_TX_SHAPE);
  assign we_apr = i_wr_stb && (ptr_r == OFS_ADAPT_PRI);
  assign we_asc = i_wr_stb && (ptr_r == OFS_ADAPT_SEC);

  cfg_byte #(.RESET_VALUE(RST_GENERAL), .WRITE_MASK(WMASK_GENERAL))
    u_general (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we_gen),
    .i_wdata(i_wr_data),
    .o_q(gen_q)
  );

  cfg_byte #(.RESET_VALUE(RST_TX_SHAPE), .WRITE_MASK(WMASK_TX_SHAPE))
    u_tx_shape (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we_txs),
    .i_wdata(i_wr_data),
    .o_q(txs_q)
  );

  cfg_byte #(.RESET_VALUE(RST_ADAPT_PRI), .WRITE_MASK(WMASK_ADAPT_PRI))
    u_adapt_pri (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we_apr),
    .i_wdata(i_wr_data),
    .o_q(apr_q)
  );

  cfg_byte #(.RESET_VALUE(RST_ADAPT_SEC), .WRITE_MASK(WMASK_ADAPT_SEC))
    u_adapt_sec (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_we(we_asc),
    .i_wdata(i_wr_data),
    .o_q(asc_q)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unlisted offsets read zero rather than aliasing
  always_comb begin
    case (ptr_r)
      OFS_REVISION: rd_mux = REVISION_VALUE;
      OFS_GENERAL: rd_mux = gen_q;
      OFS_TX_SHAPE: rd_mux = txs_q;
      OFS_ADAPT_PRI: rd_mux = apr_q;
      OFS_ADAPT_SEC: rd_mux = asc_q;
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_r <= BYTE_ZERO;
    end else if (rd_take) begin
      rd_data_r <= rd_mux;
    end
  end

  assign o_rd_data = rd_data_r;

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  always_comb begin
    o_cfg.host_tx_limited_mode = gen_q[GEN_LIMITED];
    o_cfg.eq_source_from_registers = gen_q[GEN_EQ_SRC];
    o_cfg.flip_orientation = gen_q[GEN_FLIP];
    o_cfg.usb_enable = gen_q[GEN_USB_LO];
    o_cfg.preshoot_level = txs_q[TX_PRE_HI:TX_PRE_LO];
    // Enables are forced on in linear mode: the enable bits are ignored there
    o_cfg.preshoot_enable =
      txs_q[TX_PRE_EN] | ~gen_q[GEN_LIMITED];
    o_cfg.deemphasis_level = txs_q[TX_DE_HI:TX_DE_LO];
    o_cfg.deemphasis_enable =
      txs_q[TX_DE_EN] | ~gen_q[GEN_LIMITED];
    o_cfg.full_adapt_upper_limit =
      apr_q[AP_UPPER_HI:AP_UPPER_LO];
    o_cfg.idle_deep_sleep_select = apr_q[AP_SLEEP];
    o_cfg.adapt_algorithm_select =
      adapt_alg_e'(apr_q[AP_ALG_HI:AP_ALG_LO]);
    o_cfg.adapt_enable = apr_q[AP_EN];
    o_cfg.final_adjust_negative = asc_q[AS_SIGN];
    o_cfg.fast_adapt_limit = asc_q[AS_LIM_HI:AS_LIM_LO];
    o_cfg.final_adjust_value = asc_q[AS_ADJ_HI:AS_ADJ_LO];
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  ptr_step_a: assert property (
    !i_ofs_load && rd_take |=> ptr_r == $past(ptr_r) + OFS_STEP)
    else $error("pointer did not advance on read");
  ofs_load_a: assert property (
    i_ofs_load |=> ptr_r == $past(i_ofs))
    else $error("offset byte not taken");
  nack_hold_a: assert property (
    i_rd_nack ##1 !i_stop [*2] |-> !o_tx_enable)
    else $error("data driven after nack");
  hold_freeze_a: assert property (
    hold_r && i_rd_stb && !i_ofs_load && !i_wr_stb |=> $stable(ptr_r))
    else $error("pointer moved during hold");
  rev_const_a: assert property (
    rd_take && ptr_r == OFS_REVISION |=> o_rd_data == REVISION_VALUE)
    else $error("revision read wrong");
  gen_resv_a: assert property (
    rd_take && ptr_r == OFS_GENERAL |=>
      (o_rd_data & ~WMASK_GENERAL) == BYTE_ZERO)
    else $error("general reserved bit set");
  usb_code_a: assert property (
    we_gen |=> o_cfg.usb_enable == $past(i_wr_data[GEN_USB_LO]))
    else $error("usb enable decode wrong");
  limit_write_a: assert property (
    we_gen |=> o_cfg.host_tx_limited_mode == $past(i_wr_data[GEN_LIMITED]))
    else $error("limited mode not written");
  pre_linear_a: assert property (
    !o_cfg.host_tx_limited_mode |-> o_cfg.preshoot_enable
      && o_cfg.deemphasis_enable)
    else $error("shaping gated in linear mode");
  algo_write_a: assert property (
    we_apr ##1 !we_apr |-> o_cfg.adapt_algorithm_select
      == $past(i_wr_data[AP_ALG_HI:AP_ALG_LO]))
    else $error("algorithm field not held");
  hold_clear_a: assert property (
    i_stop && !i_rd_nack |=> o_tx_enable)
    else $error("hold not released by stop");
  orient_write_a: assert property (
    we_gen |=> o_cfg.flip_orientation ==
      $past(i_wr_data[GEN_FLIP]))
    else $error("orientation not written");
  eq_src_write_a: assert property (
    we_gen |=> o_cfg.eq_source_from_registers ==
      $past(i_wr_data[GEN_EQ_SRC]))
    else $error("equalizer source not written");
  preshoot_write_a: assert property (
    we_txs |=> o_cfg.preshoot_level ==
      $past(i_wr_data[TX_PRE_HI:TX_PRE_LO]))
    else $error("preshoot level not written");
  deemph_write_a: assert property (
    we_txs |=> o_cfg.deemphasis_level ==
      $past(i_wr_data[TX_DE_HI:TX_DE_LO]))
    else $error("deemphasis level not written");
  deemph_gate_a: assert property (
    o_cfg.host_tx_limited_mode |->
      o_cfg.deemphasis_enable == txs_q[TX_DE_EN])
    else $error("deemphasis enable ignored in limited mode");
  upper_write_a: assert property (
    we_apr |=> o_cfg.full_adapt_upper_limit ==
      $past(i_wr_data[AP_UPPER_HI:AP_UPPER_LO]))
    else $error("upper limit not written");
  sleep_write_a: assert property (
    we_apr |=> o_cfg.idle_deep_sleep_select ==
      $past(i_wr_data[AP_SLEEP]))
    else $error("idle sleep select not written");
  adapt_en_write_a: assert property (
    we_apr |=> o_cfg.adapt_enable ==
      $past(i_wr_data[AP_EN]))
    else $error("adaptive enable not written");
  sec_resv_a: assert property (
    rd_take && ptr_r == OFS_ADAPT_SEC |=>
      (o_rd_data & ~WMASK_ADAPT_SEC) == BYTE_ZERO)
    else $error("secondary reserved bit set");
  adjust_write_a: assert property (
    we_asc |=> o_cfg.final_adjust_value ==
      $past(i_wr_data[AS_ADJ_HI:AS_ADJ_LO]))
    else $error("final adjustment not written");

endmodule

// ==== verilog/redriver_cfg_pkg.sv ====
// Package of offsets, layouts and reset values for the config bank
package redriver_cfg_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_REVISION = 8'h08;
  localparam logic [7:0] OFS_GENERAL = 8'h0a;
  localparam logic [7:0] OFS_TX_SHAPE = 8'h0b;
  localparam logic [7:0] OFS_ADAPT_PRI = 8'h1c;
  localparam logic [7:0] OFS_ADAPT_SEC = 8'h1d;
  localparam logic [7:0] OFS_STEP = 8'h01;

  // ****************************************************************
  // Reset values and writable bit masks
  // ****************************************************************
  // Arbitrary neutral value, not a real part's code
  localparam logic [7:0] REVISION_VALUE = 8'h5a;
  localparam logic [7:0] RST_GENERAL = 8'h00;
  localparam logic [7:0] RST_TX_SHAPE = 8'h6f;
  localparam logic [7:0] RST_ADAPT_PRI = 8'h85;
  localparam logic [7:0] RST_ADAPT_SEC = 8'h10;
  localparam logic [7:0] WMASK_GENERAL = 8'h97;
  localparam logic [7:0] WMASK_TX_SHAPE = 8'hff;
  localparam logic [7:0] WMASK_ADAPT_PRI = 8'hff;
  localparam logic [7:0] WMASK_ADAPT_SEC = 8'hbf;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GEN_LIMITED = 7;
  localparam int GEN_EQ_SRC = 4;
  localparam int GEN_FLIP = 2;
  localparam int GEN_USB_HI = 1;
  localparam int GEN_USB_LO = 0;
  localparam int TX_PRE_HI = 7;
  localparam int TX_PRE_LO = 6;
  localparam int TX_PRE_EN = 5;
  localparam int TX_DE_HI = 4;
  localparam int TX_DE_LO = 3;
  localparam int TX_DE_EN = 2;
  localparam int AP_UPPER_HI = 7;
  localparam int AP_UPPER_LO = 4;
  localparam int AP_SLEEP = 3;
  localparam int AP_ALG_HI = 2;
  localparam int AP_ALG_LO = 1;
  localparam int AP_EN = 0;
  localparam int AS_SIGN = 7;
  localparam int AS_LIM_HI = 5;
  localparam int AS_LIM_LO = 3;
  localparam int AS_ADJ_HI = 2;
  localparam int AS_ADJ_LO = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ALG_FAST, ALG_FULL_EVERY, ALG_FULL_II, ALG_FULL_FIRST
  } adapt_alg_e;

  typedef struct packed {
    logic host_tx_limited_mode;
    logic eq_source_from_registers;
    logic flip_orientation;
    logic usb_enable;
    logic [1:0] preshoot_level;
    logic preshoot_enable;
    logic [1:0] deemphasis_level;
    logic deemphasis_enable;
    logic [3:0] full_adapt_upper_limit;
    logic idle_deep_sleep_select;
    adapt_alg_e adapt_algorithm_select;
    logic adapt_enable;
    logic final_adjust_negative;
    logic [2:0] fast_adapt_limit;
    logic [2:0] final_adjust_value;
  } cfg_s;

endpackage

// ==== verilog/cfg_byte.sv ====
// One writable configuration byte with per-bit write mask
`timescale 1ns/10ps
module cfg_byte #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_q
);

  logic [7:0] q_r;

  // Masked bits hold their reset value, so reserved bits stay zero
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_r <= RESET_VALUE;
    end else if (i_we) begin
      q_r <= (i_wdata & WRITE_MASK) | (q_r & ~WRITE_MASK);
    end
  end

  assign o_q = q_r;

endmodule

// ==== dv/cfg_host_model.sv ====
// Controller-side model that drives the transaction strobes of the bank
`timescale 1ns/10ps
module cfg_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rd_data,
  output logic o_ofs_load,
  output logic [7:0] o_ofs,
  output logic o_wr_stb,
  output logic [7:0] o_wr_data,
  output logic o_rd_stb,
  output logic o_rd_nack,
  output logic o_stop
);
  // ****************************************************************
  // Strobe tasks, one edge per byte
  // ****************************************************************
  initial begin
    o_ofs_load = 1'b0;
    o_ofs = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 8'h00;
    o_rd_stb = 1'b0;
    o_rd_nack = 1'b0;
    o_stop = 1'b0;
  end
  // Released data shows the inverse, so stale values never match
  task automatic load(input logic [7:0] ofs);
    @(posedge i_mclk);
    o_ofs_load <= 1'b1;
    o_ofs <= ofs;
    @(posedge i_mclk);
    o_ofs_load <= 1'b0;
    o_ofs <= ~ofs;
  endtask
  task automatic put(input logic [7:0] d);
    @(posedge i_mclk);
    o_wr_stb <= 1'b1;
    o_wr_data <= d;
    @(posedge i_mclk);
    o_wr_stb <= 1'b0;
    o_wr_data <= ~d;
  endtask
  task automatic get(output logic [7:0] d);
    @(posedge i_mclk);
    o_rd_stb <= 1'b1;
    @(posedge i_mclk);
    o_rd_stb <= 1'b0;
    #1 d = i_rd_data;
  endtask
  task automatic nack_pulse();
    @(posedge i_mclk);
    o_rd_nack <= 1'b1;
    @(posedge i_mclk);
    o_rd_nack <= 1'b0;
    #1;
  endtask
  task automatic stop_pulse();
    @(posedge i_mclk);
    o_stop <= 1'b1;
    @(posedge i_mclk);
    o_stop <= 1'b0;
    #1;
  endtask
endmodule

// ==== dv/redriver_config_registers_tb.sv ====
// Self-checking bench for the redriver configuration bank
`timescale 1ns/10ps
module redriver_config_registers_tb;
  import redriver_cfg_pkg::*;
  logic i_mclk, i_nrst, ofs_load, wr_stb, rd_stb, rd_nack, stop, tx_en;
  logic [7:0] ofs, wr_data, rd_data, pointer, d;
  cfg_s cfg;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // ****************************************************************
  // Harness
  // ****************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  cfg_host_model u_host (.i_mclk(i_mclk), .i_rd_data(rd_data),
    .o_ofs_load(ofs_load), .o_ofs(ofs), .o_wr_stb(wr_stb),
    .o_wr_data(wr_data), .o_rd_stb(rd_stb), .o_rd_nack(rd_nack),
    .o_stop(stop));
  redriver_config_registers u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_ofs_load(ofs_load), .i_ofs(ofs), .i_wr_stb(wr_stb),
    .i_wr_data(wr_data), .i_rd_stb(rd_stb), .i_rd_nack(rd_nack),
    .i_stop(stop), .o_rd_data(rd_data), .o_tx_enable(tx_en),
    .o_pointer(pointer), .o_cfg(cfg));
  // Ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] o, input logic [7:0] e[$]);
    logic [7:0] v;
    u_host.load(o);
    foreach (e[k]) begin
      u_host.get(v);
      check(v, e[k]);
    end
    u_host.stop_pulse();
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] q[$]);
    u_host.load(o);
    foreach (q[k]) u_host.put(q[k]);
    u_host.stop_pulse();
  endtask
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    i_nrst = 1'b0;
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    check(cfg.host_tx_limited_mode, 1'b0);
    check(cfg.eq_source_from_registers, 1'b0);
    check({cfg.flip_orientation, cfg.usb_enable}, 2'h0);
    check({cfg.preshoot_enable, cfg.deemphasis_enable},
      2'h3);
    check({cfg.preshoot_level, cfg.deemphasis_level},
      4'h5);
    check({cfg.full_adapt_upper_limit, cfg.idle_deep_sleep_select},
      5'h10);
    check({cfg.adapt_algorithm_select, cfg.adapt_enable},
      3'h5);
    check({cfg.final_adjust_negative, cfg.fast_adapt_limit,
      cfg.final_adjust_value}, 7'h10);
    rd_chk(OFS_REVISION, '{8'h5a, 8'h00, 8'h00, 8'h6f});
    rd_chk(OFS_ADAPT_PRI, '{8'h85, 8'h10});
    // Burst over the revision and a hole before the live bytes
    wr(OFS_REVISION, '{8'h00, 8'hff, 8'hff, 8'h03});
    rd_chk(OFS_REVISION, '{8'h5a, 8'h00, 8'h97, 8'h03});
    check({cfg.host_tx_limited_mode, cfg.eq_source_from_registers,
      cfg.flip_orientation, cfg.usb_enable}, 4'hf);
    check({cfg.preshoot_enable, cfg.deemphasis_enable},
      2'h0);
    wr(OFS_GENERAL, '{8'h00});
    check({cfg.preshoot_enable, cfg.deemphasis_enable},
      2'h3);
    check({cfg.host_tx_limited_mode, cfg.eq_source_from_registers,
      cfg.flip_orientation}, 3'h0);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_GENERAL, '{8'(c)});
      check(cfg.usb_enable, c[0]);
      wr(OFS_TX_SHAPE, '{8'(c * 72)});
      check({cfg.preshoot_level, cfg.deemphasis_level},
        {2'(c), 2'(c)});
      wr(OFS_ADAPT_PRI, '{8'(c * 18 + 8)});
      check({cfg.full_adapt_upper_limit, cfg.idle_deep_sleep_select,
        cfg.adapt_algorithm_select, cfg.adapt_enable},
        {4'(c), 1'b1, 2'(c), 1'b0});
    end
    wr(OFS_ADAPT_SEC, '{8'hff});
    rd_chk(OFS_ADAPT_SEC, '{8'hbf});
    check({cfg.final_adjust_negative, cfg.fast_adapt_limit,
      cfg.final_adjust_value}, 7'h7f);
    // Offset wraps from the top of the byte range
    rd_chk(8'hff, '{8'h00, 8'h00});
    check(pointer, 8'h01);
    // After a refused byte no data moves until the stop
    u_host.load(OFS_GENERAL);
    u_host.get(d);
    check(d, 8'h03);
    u_host.nack_pulse();
    check(tx_en, 1'b0);
    u_host.get(d);
    check({pointer, d}, {OFS_TX_SHAPE, 8'h03});
    u_host.stop_pulse();
    check(tx_en, 1'b1);
    // Reset in mid-run drops a pending hold and restores the defaults
    u_host.nack_pulse();
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    #1;
    check({tx_en, pointer}, 9'h100);
    check({cfg.host_tx_limited_mode, cfg.usb_enable,
      cfg.adapt_algorithm_select}, 4'h2);
    rd_chk(OFS_ADAPT_SEC, '{8'h10});
    end_sim();
  end
endmodule
